// ==== nspu_map.vh ====
// Constants for the nibble stack pointer unit
`ifndef NSPU_MAP_VH
`define NSPU_MAP_VH

// ==========================================================
// Register addresses and reset values
`define NSPU_SP_LO_ADDR   12'hF80
`define NSPU_SP_HI_ADDR   12'hF81
`define NSPU_SP_RESET     8'h00
`define NSPU_STACK_BANK   4'h0

// ==========================================================
// Stack operation codes
`define NSPU_OP_PUSH_PAIR 4'h0
`define NSPU_OP_POP_PAIR  4'h1
`define NSPU_OP_PUSH_SB   4'h2
`define NSPU_OP_POP_SB    4'h3
`define NSPU_OP_CALL      4'h4
`define NSPU_OP_RET       4'h5
`define NSPU_OP_SKIP_RETURN      4'h6
`define NSPU_OP_INTR      4'h7
`define NSPU_OP_INTERRUPT_RETURN      4'h8

// ==========================================================
// Nibble counts and field positions
`define NSPU_PAIR_NIBS    3'd2
`define NSPU_FRAME_NIBS   3'd6
`define NSPU_FRAME_EMB    15
`define NSPU_FRAME_ERB    14
`define NSPU_PSW_EMB      1
`define NSPU_PSW_ERB      0

`endif

// ==== nspu_bank.v ====
// Memory and register bank selection state
`timescale 1ns/1ns
`default_nettype none

module nspu_bank (
  input  wire       clk_in,
  input  wire       nrst_in,
  input  wire       ce_in,
  input  wire       set_smb_in,
  input  wire       set_srb_in,
  input  wire [3:0] value_in,
  input  wire       set_flags_in,
  input  wire       emb_in,
  input  wire       erb_in,
  input  wire       load_sb_in,
  input  wire [7:0] sb_in,
  output reg  [3:0] smb_out,
  output reg  [1:0] srb_out,
  output reg        emb_out,
  output reg        erb_out,
  output reg  [1:0] rbank_out
);

  reg [1:0] srb_d;
  reg       erb_d;

  always @* begin
    erb_d = set_flags_in ? erb_in : erb_out;
    srb_d = srb_out;
    if (load_sb_in) begin
      srb_d = sb_in[1:0];
    end else if (set_srb_in && erb_out) begin
      srb_d = value_in[1:0];
    end
  end

  always @(posedge clk_in) begin
    if (!nrst_in) begin
      smb_out   <= 4'h0;
      srb_out   <= 2'b00;
      emb_out   <= 1'b0;
      erb_out   <= 1'b0;
      rbank_out <= 2'b00;
    end else if (ce_in) begin
      if (load_sb_in) begin
        smb_out <= sb_in[7:4];
      end else if (set_smb_in) begin
        smb_out <= value_in;
      end
      if (set_flags_in) begin
        emb_out <= emb_in;
      end
      srb_out   <= srb_d;
      erb_out   <= erb_d;
      // Bank 0 is forced while the enable flag is clear
      rbank_out <= erb_d ? srb_d : 2'b00;
    end
  end

endmodule
`default_nettype wire

// ==== nspu_top.v ====
// Nibble stack pointer unit: pointer, stack sequencer, bank state
`include "nspu_map.vh"
`timescale 1ns/1ns
`default_nettype none

module nspu_top (
  input  wire        CLK_IN,
  input  wire        NRST_IN,
  input  wire        CE_IN,
  input  wire        OP_VALID_IN,
  input  wire [3:0]  OP_IN,
  input  wire [7:0]  PAIR_DATA_IN,
  input  wire [12:0] PC_IN,
  input  wire [7:0]  PSW_IN,
  input  wire        SET_SMB_IN,
  input  wire        SET_SRB_IN,
  input  wire [3:0]  BANK_VALUE_IN,
  input  wire        SET_FLAGS_IN,
  input  wire        EMB_IN,
  input  wire        ERB_IN,
  input  wire [11:0] SFR_ADDR_IN,
  input  wire        SFR_RD_IN,
  input  wire        SFR_WR_IN,
  input  wire        SFR_WIDE_IN,
  input  wire [7:0]  SFR_WDATA_IN,
  input  wire [3:0]  MEM_RDATA_IN,
  output reg  [7:0]  SFR_RDATA_OUT,
  output reg  [11:0] MEM_ADDR_OUT,
  output reg         MEM_WE_OUT,
  output reg         MEM_RE_OUT,
  output reg  [3:0]  MEM_WDATA_OUT,
  output reg         BUSY_OUT,
  output reg         DONE_OUT,
  output reg         SKIP_OUT,
  output reg  [7:0]  POP_DATA_OUT,
  output reg  [12:0] PC_OUT,
  output reg  [7:0]  PSW_OUT,
  output wire [3:0]  SMB_OUT,
  output wire [1:0]  SRB_OUT,
  output wire        EMB_OUT,
  output wire        ERB_OUT,
  output wire [1:0]  RBANK_OUT
);
  // ========================================================
  // State and storage
  localparam [1:0] ST_IDLE   = 2'd0;
  localparam [1:0] ST_PUSH   = 2'd1;
  localparam [1:0] ST_POP    = 2'd2;
  localparam [1:0] ST_FINISH = 2'd3;
  reg  [1:0]  st_q, flags_q;
  reg  [7:0]  sp_q;
  reg  [3:0]  op_q;
  reg  [2:0]  nibs_q, idx_q, pend_idx_q, nibs_d;
  reg  [23:0] word_q, word_d;
  reg         pend_q, load_sb_q, load_flags_q, is_push_d;
  wire        start, sfr_lo, sfr_hi;
  // ========================================================
  // Helpers
  // Stack lives in bank 0 whatever the bank flags hold
  function [11:0] stack_addr;
    input [7:0] base;
    input [7:0] offs;
    begin
      stack_addr = {`NSPU_STACK_BANK, base + offs};
    end
  endfunction
  function is_sfr;
    input [11:0] addr;
    input [11:0] target;
    begin
      is_sfr = (addr == target);
    end
  endfunction
  assign start  = (st_q == ST_IDLE) && OP_VALID_IN;
  assign sfr_lo = is_sfr(SFR_ADDR_IN, `NSPU_SP_LO_ADDR);
  assign sfr_hi = is_sfr(SFR_ADDR_IN, `NSPU_SP_HI_ADDR);

  // ========================================================
  // Frame assembly; nibble 0 sits at the lowest address
  always @* begin
    word_d    = 24'h00_0000;
    nibs_d    = `NSPU_FRAME_NIBS;
    is_push_d = 1'b0;
    case (OP_IN)
      `NSPU_OP_PUSH_PAIR: begin
        word_d    = {16'h0000, PAIR_DATA_IN};
        nibs_d    = `NSPU_PAIR_NIBS;
        is_push_d = 1'b1;
      end
      `NSPU_OP_PUSH_SB: begin
        word_d    = {16'h0000, SMB_OUT, 2'b00, SRB_OUT};
        nibs_d    = `NSPU_PAIR_NIBS;
        is_push_d = 1'b1;
      end
      `NSPU_OP_CALL: begin
        word_d = {8'h00, EMB_OUT, ERB_OUT, 2'b00, PC_IN[11:0]};
        word_d[12] = PC_IN[12];
        is_push_d  = 1'b1;
      end
      `NSPU_OP_INTR: begin
        word_d    = {PSW_IN, 3'b000, PC_IN};
        is_push_d = 1'b1;
      end
      `NSPU_OP_POP_PAIR, `NSPU_OP_POP_SB: begin
        nibs_d = `NSPU_PAIR_NIBS;
      end
      default: nibs_d = `NSPU_FRAME_NIBS;
    endcase
  end
  // ========================================================
  // Sequencer and pointer
  // Stack operations move the pointer only in FINISH, so no partial value is ever seen
  always @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      st_q          <= ST_IDLE;
      sp_q          <= `NSPU_SP_RESET;
      op_q          <= 4'h0;
      nibs_q        <= 3'd0;
      idx_q         <= 3'd0;
      word_q        <= 24'h00_0000;
      pend_q        <= 1'b0;
      pend_idx_q    <= 3'd0;
      load_sb_q     <= 1'b0;
      load_flags_q  <= 1'b0;
      flags_q       <= 2'b00;
      SFR_RDATA_OUT <= 8'h00;
      MEM_ADDR_OUT  <= 12'h000;
      MEM_WE_OUT    <= 1'b0;
      MEM_RE_OUT    <= 1'b0;
      MEM_WDATA_OUT <= 4'h0;
      BUSY_OUT      <= 1'b0;
      DONE_OUT      <= 1'b0;
      SKIP_OUT      <= 1'b0;
      POP_DATA_OUT  <= 8'h00;
      PC_OUT        <= 13'h0000;
      PSW_OUT       <= 8'h00;
    end else if (CE_IN) begin
      DONE_OUT     <= 1'b0;
      SKIP_OUT     <= 1'b0;
      load_sb_q    <= 1'b0;
      load_flags_q <= 1'b0;
      MEM_WE_OUT   <= 1'b0;
      MEM_RE_OUT   <= 1'b0;
      pend_q       <= 1'b0;
      if (SFR_RD_IN) begin
        // Narrow reads return the addressed nibble in bits 3:0
        if (sfr_lo) begin
          SFR_RDATA_OUT <= SFR_WIDE_IN ? sp_q : {4'h0, sp_q[3:0]};
        end else if (sfr_hi) begin
          SFR_RDATA_OUT <= {4'h0, sp_q[7:4]};
        end else begin
          SFR_RDATA_OUT <= 8'h00;
        end
      end
      // Software writes land only between stack operations
      if (SFR_WR_IN && st_q == ST_IDLE && !OP_VALID_IN) begin
        if (sfr_lo && SFR_WIDE_IN) begin
          sp_q <= {SFR_WDATA_IN[7:1], 1'b0};
        end else if (sfr_lo) begin
          sp_q[3:0] <= {SFR_WDATA_IN[3:1], 1'b0};
        end else if (sfr_hi) begin
          sp_q[7:4] <= SFR_WDATA_IN[3:0];
        end
      end
      case (st_q)
        ST_IDLE: begin
          if (start) begin
            op_q     <= OP_IN;
            nibs_q   <= nibs_d;
            word_q   <= word_d;
            BUSY_OUT <= 1'b1;
            if (is_push_d) begin
              // Highest nibble first, at pointer minus one
              idx_q <= nibs_d - 3'd1;
              st_q  <= ST_PUSH;
            end else begin
              idx_q <= 3'd0;
              st_q  <= ST_POP;
            end
          end
        end
        ST_PUSH: begin
          MEM_WE_OUT    <= 1'b1;
          MEM_ADDR_OUT  <= stack_addr(sp_q, {5'h00, idx_q}
                                      - {5'h00, nibs_q});
          MEM_WDATA_OUT <= word_q[idx_q*4 +: 4];
          if (idx_q == 3'd0) begin
            st_q <= ST_FINISH;
          end else begin
            idx_q <= idx_q - 3'd1;
          end
        end
        ST_POP: begin
          // Memory read data is expected in the cycle the address is shown
          if (idx_q != nibs_q) begin
            MEM_RE_OUT   <= 1'b1;
            MEM_ADDR_OUT <= stack_addr(sp_q, {5'h00, idx_q});
            pend_q       <= 1'b1;
            pend_idx_q   <= idx_q;
            idx_q        <= idx_q + 3'd1;
          end
          if (pend_q) begin
            word_q[pend_idx_q*4 +: 4] <= MEM_RDATA_IN;
            if (pend_idx_q == nibs_q - 3'd1) begin
              st_q <= ST_FINISH;
            end
          end
        end
        ST_FINISH: begin
          st_q     <= ST_IDLE;
          BUSY_OUT <= 1'b0;
          DONE_OUT <= 1'b1;
          case (op_q)
            `NSPU_OP_PUSH_PAIR, `NSPU_OP_PUSH_SB,
            `NSPU_OP_CALL, `NSPU_OP_INTR: begin
              sp_q <= sp_q - {5'h00, nibs_q};
            end
            default: begin
              sp_q <= sp_q + {5'h00, nibs_q};
            end
          endcase
          case (op_q)
            `NSPU_OP_POP_PAIR: begin
              POP_DATA_OUT <= word_q[7:0];
            end
            `NSPU_OP_POP_SB: begin
              load_sb_q <= 1'b1;
            end
            `NSPU_OP_RET, `NSPU_OP_SKIP_RETURN: begin
              PC_OUT       <= word_q[12:0];
              flags_q      <= {word_q[`NSPU_FRAME_EMB],
                               word_q[`NSPU_FRAME_ERB]};
              load_flags_q <= 1'b1;
              SKIP_OUT     <= (op_q == `NSPU_OP_SKIP_RETURN);
            end
            `NSPU_OP_INTERRUPT_RETURN: begin
              PC_OUT       <= word_q[12:0];
              PSW_OUT      <= word_q[23:16];
              flags_q      <= {word_q[16 + `NSPU_PSW_EMB],
                               word_q[16 + `NSPU_PSW_ERB]};
              load_flags_q <= 1'b1;
            end
            default: load_sb_q <= 1'b0;
          endcase
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end
  // ========================================================
  // Bank selection
  // Restored flags land one cycle after DONE_OUT
  nspu_bank u_bank (
    .clk_in       (CLK_IN),
    .nrst_in      (NRST_IN),
    .ce_in        (CE_IN),
    .set_smb_in   (SET_SMB_IN),
    .set_srb_in   (SET_SRB_IN),
    .value_in     (BANK_VALUE_IN),
    .set_flags_in (SET_FLAGS_IN | load_flags_q),
    .emb_in       (load_flags_q ? flags_q[1] : EMB_IN),
    .erb_in       (load_flags_q ? flags_q[0] : ERB_IN),
    .load_sb_in   (load_sb_q),
    .sb_in        (word_q[7:0]),
    .smb_out      (SMB_OUT),
    .srb_out      (SRB_OUT),
    .emb_out      (EMB_OUT),
    .erb_out      (ERB_OUT),
    .rbank_out    (RBANK_OUT)
  );

endmodule
`default_nettype wire

// ==== nspu_mem_model.sv ====
// Bank-0 data memory model seen by the stack unit
`timescale 1ns/1ns
`default_nettype none
module nspu_mem_model (
  input  wire logic        clk_in,
  input  wire logic        we_in,
  input  wire logic        re_in,
  input  wire logic [11:0] addr_in,
  input  wire logic [3:0]  wdata_in,
  output logic      [3:0]  rdata_out
);
  logic [3:0] mem_q [0:255];
  int         bad_q = 0;
  // ==========================================================
  // Storage
  always @(posedge clk_in) begin
    if (we_in) begin
      mem_q[addr_in[7:0]] <= wdata_in;
      if (addr_in[11:8] != 4'h0)
        bad_q <= bad_q + 1;
    end
  end
  // Not read: a toggling pattern so stale data never looks valid
  assign rdata_out = re_in ? mem_q[addr_in[7:0]] : {4{clk_in}} ^ 4'h5;
endmodule
`default_nettype wire

// ==== nspu_top_chk.sv ====
// Port-level checker for the nibble stack unit
`timescale 1ns/1ns
`default_nettype none
module nspu_top_chk (
  input wire logic        CLK_IN,
  input wire logic        NRST_IN,
  input wire logic        CE_IN,
  input wire logic        OP_VALID_IN,
  input wire logic [3:0]  OP_IN,
  input wire logic [11:0] SFR_ADDR_IN,
  input wire logic        SFR_RD_IN,
  input wire logic        SFR_WIDE_IN,
  input wire logic [7:0]  SFR_RDATA_OUT,
  input wire logic [11:0] MEM_ADDR_OUT,
  input wire logic        MEM_WE_OUT,
  input wire logic        MEM_RE_OUT,
  input wire logic        BUSY_OUT,
  input wire logic        DONE_OUT,
  input wire logic        SKIP_OUT,
  input wire logic [1:0]  SRB_OUT,
  input wire logic        ERB_OUT,
  input wire logic [1:0]  RBANK_OUT
);
  logic       we_q, re_q;
  logic [7:0] adr_q;
  always @(posedge CLK_IN) begin
    we_q  <= NRST_IN & MEM_WE_OUT;
    re_q  <= NRST_IN & MEM_RE_OUT;
    adr_q <= MEM_ADDR_OUT[7:0];
  end
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);
  // ==========================================================
  // Sequences
  sequence s_take;
    OP_VALID_IN && !BUSY_OUT && CE_IN;
  endsequence
  sequence s_wr2; BUSY_OUT ##1 MEM_WE_OUT [*2] ##1 DONE_OUT; endsequence
  sequence s_wr6; BUSY_OUT ##1 MEM_WE_OUT [*6] ##1 DONE_OUT; endsequence
  sequence s_rd2; BUSY_OUT ##1 MEM_RE_OUT [*2] ##2 DONE_OUT; endsequence
  sequence s_rd6; BUSY_OUT ##1 MEM_RE_OUT [*6] ##2 DONE_OUT; endsequence
  // ==========================================================
  // Assertions
  AST_PAIR_PUSH: assert property (s_take ##0 (OP_IN == 4'h0 ||
    OP_IN == 4'h2) |=> s_wr2) else $error("pair push timing wrong");
  AST_FRAME_PUSH: assert property (s_take ##0 (OP_IN == 4'h4 ||
    OP_IN == 4'h7) |=> s_wr6) else $error("frame push timing wrong");
  AST_PAIR_POP: assert property (s_take ##0 (OP_IN == 4'h1 ||
    OP_IN == 4'h3) |=> s_rd2) else $error("pair pop timing wrong");
  AST_FRAME_POP: assert property (s_take ##0 (OP_IN == 4'h5 ||
    OP_IN == 4'h6 || OP_IN == 4'h8) |=> s_rd6)
    else $error("frame pop timing wrong");
  AST_BANK_ZERO: assert property ((MEM_WE_OUT || MEM_RE_OUT) |->
    MEM_ADDR_OUT[11:8] == 4'h0) else $error("stack left bank 0");
  AST_PUSH_DOWN: assert property (MEM_WE_OUT && we_q |->
    MEM_ADDR_OUT[7:0] == adr_q - 8'h01) else $error("push not descending");
  AST_POP_UP: assert property (MEM_RE_OUT && re_q |->
    MEM_ADDR_OUT[7:0] == adr_q + 8'h01) else $error("pop not ascending");
  AST_SP_EVEN: assert property (SFR_RD_IN && SFR_WIDE_IN && CE_IN &&
    SFR_ADDR_IN == 12'hF80 |=> !SFR_RDATA_OUT[0])
    else $error("pointer bit 0 set");
  AST_RBANK: assert property (RBANK_OUT == (ERB_OUT ? SRB_OUT : 2'h0))
    else $error("working bank wrong");
  AST_SKIP: assert property (SKIP_OUT |-> DONE_OUT && !BUSY_OUT)
    else $error("skip without done");
endmodule
bind nspu_top nspu_top_chk u_nspu_top_chk (.CLK_IN(CLK_IN),
  .NRST_IN(NRST_IN), .CE_IN(CE_IN), .OP_VALID_IN(OP_VALID_IN),
  .OP_IN(OP_IN), .SFR_ADDR_IN(SFR_ADDR_IN), .SFR_RD_IN(SFR_RD_IN),
  .SFR_WIDE_IN(SFR_WIDE_IN), .SFR_RDATA_OUT(SFR_RDATA_OUT),
  .MEM_ADDR_OUT(MEM_ADDR_OUT), .MEM_WE_OUT(MEM_WE_OUT),
  .MEM_RE_OUT(MEM_RE_OUT), .BUSY_OUT(BUSY_OUT), .DONE_OUT(DONE_OUT),
  .SKIP_OUT(SKIP_OUT), .SRB_OUT(SRB_OUT), .ERB_OUT(ERB_OUT),
  .RBANK_OUT(RBANK_OUT));
`default_nettype wire

// ==== nspu_top_tb_top.sv ====
// Self-checking testbench for the nibble stack unit
`timescale 1ns/1ns
`default_nettype none
module nspu_top_tb_top;
  logic CLK_IN = 0, NRST_IN = 0, CE_IN = 1, OP_VALID_IN = 0;
  logic [3:0] OP_IN = 0, BANK_VALUE_IN = 0, MEM_RDATA_IN;
  logic [7:0] PAIR_DATA_IN = 0, PSW_IN = 0, SFR_WDATA_IN = 0;
  logic [12:0] PC_IN = 0;
  logic SET_SMB_IN = 0, SET_SRB_IN = 0, SET_FLAGS_IN = 0, EMB_IN = 0;
  logic ERB_IN = 0, SFR_RD_IN = 0, SFR_WR_IN = 0, SFR_WIDE_IN = 0;
  logic [11:0] SFR_ADDR_IN = 0, MEM_ADDR_OUT;
  logic [7:0] SFR_RDATA_OUT, POP_DATA_OUT, PSW_OUT;
  logic MEM_WE_OUT, MEM_RE_OUT, BUSY_OUT, DONE_OUT, SKIP_OUT, skip_seen;
  logic [3:0] MEM_WDATA_OUT, SMB_OUT;
  logic [12:0] PC_OUT;
  logic [1:0] SRB_OUT, RBANK_OUT;
  logic EMB_OUT, ERB_OUT;
  int err_total = 0, check_count = 0, cyc = 0;
  nspu_top u_nspu_top (.CLK_IN, .NRST_IN, .CE_IN, .OP_VALID_IN, .OP_IN,
    .PAIR_DATA_IN, .PC_IN, .PSW_IN, .SET_SMB_IN, .SET_SRB_IN,
    .BANK_VALUE_IN, .SET_FLAGS_IN, .EMB_IN, .ERB_IN, .SFR_ADDR_IN,
    .SFR_RD_IN, .SFR_WR_IN, .SFR_WIDE_IN, .SFR_WDATA_IN, .MEM_RDATA_IN,
    .SFR_RDATA_OUT, .MEM_ADDR_OUT, .MEM_WE_OUT, .MEM_RE_OUT,
    .MEM_WDATA_OUT, .BUSY_OUT, .DONE_OUT, .SKIP_OUT, .POP_DATA_OUT,
    .PC_OUT, .PSW_OUT, .SMB_OUT, .SRB_OUT, .EMB_OUT, .ERB_OUT,
    .RBANK_OUT);
  nspu_mem_model u_nspu_mem_model (.clk_in(CLK_IN), .we_in(MEM_WE_OUT),
    .re_in(MEM_RE_OUT), .addr_in(MEM_ADDR_OUT),
    .wdata_in(MEM_WDATA_OUT), .rdata_out(MEM_RDATA_IN));
  always #2 CLK_IN = ~CLK_IN;
  // ==========================================================
  // Shared tasks
  task give_verdict;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge CLK_IN) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      give_verdict;
    end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      err_total++;
    end
  endtask
  task sfr(input logic wr, input logic [11:0] a, input logic w,
           input logic [7:0] d);
    SFR_ADDR_IN = a; SFR_WIDE_IN = w; SFR_WDATA_IN = d;
    SFR_WR_IN = wr; SFR_RD_IN = !wr;
    @(posedge CLK_IN); #1 SFR_WR_IN = 0; SFR_RD_IN = 0;
    // Idle edge so a following access never re-drives in this time step
    @(posedge CLK_IN); #1;
  endtask
  task rd(input logic [11:0] a, input logic w, input logic [7:0] e);
    sfr(0, a, w, 8'h00);
    chk({8'h00, SFR_RDATA_OUT}, {8'h00, e});
  endtask
  task mem(input logic [7:0] a, input logic [3:0] e);
    chk({12'h000, u_nspu_mem_model.mem_q[a]}, {12'h000, e});
  endtask
  task bank(input logic s, input logic r, input logic f,
            input logic [3:0] v);
    SET_SMB_IN = s; SET_SRB_IN = r; SET_FLAGS_IN = f; BANK_VALUE_IN = v;
    EMB_IN = v[3]; ERB_IN = v[0];
    @(posedge CLK_IN); #1 {SET_SMB_IN, SET_SRB_IN, SET_FLAGS_IN} = 0;
    @(posedge CLK_IN); #1;
  endtask
  // Waits for done under a bound; one spare cycle lets bank state land
  task wait_done;
    int n;
    for (n = 0; n < 20 && DONE_OUT !== 1'b1; n++) begin
      @(posedge CLK_IN); #1;
    end
    chk({15'h0000, DONE_OUT}, 16'h0001);
    skip_seen = SKIP_OUT;
    @(posedge CLK_IN); #1;
  endtask
  task run_op(input logic [3:0] op);
    OP_IN = op; OP_VALID_IN = 1;
    @(posedge CLK_IN); #1 OP_VALID_IN = 0;
    wait_done;
  endtask
  // ==========================================================
  // Scenarios
  task t_ptr;
    sfr(1, 12'hF80, 1, 8'h37); rd(12'hF80, 1, 8'h36);
    rd(12'hF80, 0, 8'h06); rd(12'hF81, 0, 8'h03);
    sfr(1, 12'hF81, 0, 8'h0A); rd(12'hF80, 1, 8'hA6);
    rd(12'hF82, 1, 8'h00);
    sfr(1, 12'hF80, 1, 8'h00);
  endtask
  task t_pair;
    PAIR_DATA_IN = 8'h5A; run_op(4'h0);
    mem(8'hFF, 4'h5); mem(8'hFE, 4'hA);
    rd(12'hF80, 1, 8'hFE);
    PAIR_DATA_IN = 8'h3C; run_op(4'h0); run_op(4'h1);
    chk({8'h00, POP_DATA_OUT}, 16'h003C);
    run_op(4'h1); chk({8'h00, POP_DATA_OUT}, 16'h005A);
    rd(12'hF80, 1, 8'h00);
  endtask
  task t_bank;
    bank(0, 0, 1, 4'h8); bank(0, 1, 0, 4'h2);
    chk({14'h0000, RBANK_OUT}, 16'h0000);
    // Select ignored while disabled must not surface once enabled
    bank(0, 0, 1, 4'h9);
    chk({14'h0000, RBANK_OUT}, 16'h0000);
    bank(0, 1, 0, 4'h2);
    chk({14'h0000, RBANK_OUT}, 16'h0002);
    bank(1, 0, 0, 4'h9); run_op(4'h2);
    mem(8'hFF, 4'h9); mem(8'hFE, 4'h2);
    bank(1, 0, 0, 4'h0); bank(0, 1, 0, 4'h1); run_op(4'h3);
    chk({10'h000, SMB_OUT, SRB_OUT}, 16'h0026);
  endtask
  task t_call;
    sfr(1, 12'hF80, 1, 8'h04); bank(0, 0, 1, 4'h8);
    PC_IN = 13'h1ABC; run_op(4'h4); rd(12'hF80, 1, 8'hFE);
    bank(0, 0, 1, 4'h1); run_op(4'h6);
    chk({3'h0, PC_OUT}, 16'h1ABC);
    chk({14'h0000, EMB_OUT, ERB_OUT}, 16'h0002);
    chk({15'h0000, skip_seen}, 16'h0001);
    rd(12'hF80, 1, 8'h04);
    run_op(4'h4); run_op(4'h5);
    chk({15'h0000, skip_seen}, 16'h0000);
  endtask
  task t_intr;
    PC_IN = 13'h0123; PSW_IN = 8'hA5; run_op(4'h7);
    rd(12'hF80, 1, 8'hFE);
    PC_IN = 13'h0000; PSW_IN = 8'h00; run_op(4'h8);
    chk({PSW_OUT, 8'h00}, 16'hA500);
    chk({3'h0, PC_OUT}, 16'h0123); rd(12'hF80, 1, 8'h04);
  endtask
  task t_busy;
    PAIR_DATA_IN = 8'h77; OP_IN = 4'h0; OP_VALID_IN = 1;
    @(posedge CLK_IN); #1 OP_VALID_IN = 0;
    sfr(1, 12'hF80, 1, 8'h40); wait_done;
    rd(12'hF80, 1, 8'h02);
    chk(u_nspu_mem_model.bad_q[15:0], 16'h0000);
  endtask
  // Clock enable low: neither a write nor a request may land
  task t_freeze;
    CE_IN = 0; sfr(1, 12'hF80, 1, 8'h20);
    OP_IN = 4'h1; OP_VALID_IN = 1;
    @(posedge CLK_IN); #1 OP_VALID_IN = 0;
    chk({15'h0000, BUSY_OUT}, 16'h0000);
    CE_IN = 1; rd(12'hF80, 1, 8'h02);
  endtask
  initial begin
    repeat (2) @(posedge CLK_IN);
    #1 NRST_IN = 1;
    t_ptr;
    t_pair;
    t_bank;
    t_call;
    t_intr;
    t_busy;
    t_freeze;
    give_verdict;
  end
endmodule
`default_nettype wire
